// [dac_ctrl.sv]
// Conversion control and parallel read port of a dual 14-bit converter
// Contract
// [R1] Falling conversion start holds both tracks and starts both converts
// [R2] Both results reach the output register 5.2 us after start falls
// [R3] Busy ends the conversion; results readable once busy drops
// [R4] Select low: first read gives A first, second gives A second
// [R5] Select high: first read gives B first, second gives B second
// [R6] Host settles select 500 ns before next start falling edge
// [R7] Host avoids toggling select during conversion with overdriven inputs
// [R8] Read is one chip select pulse holding two read pulses
// [R9] Host leaves 400 ns after the read before next start
// [R10] Fastest read takes about 100 ns, setting the sample period
// [R11] Bipolar results are twos complement, step FS/16384
// [R12] Unipolar results are straight binary, zero at range bottom
// [R13] Bipolar code wraps all ones to all zeros half step below ground
// [R14] Bipolar extremes are 0 then 13 ones, and 1 then 13 zeros
// [R15] Busy rises on start falling and drops once results latch
// [R16] Conversion is timed internally; host supplies no clock
// [R17] Result order pointer restarts at every conversion start
// [R18] Data bus driven only while chip select and read are low
`timescale 1ns/1ps
module dac_ctrl
   import dac_pkg::*;
#(
   parameter int DATA_W = DAC_DATA_W,
   parameter int CONV_CYC = DAC_CONV_CYC,
   parameter int FIFO_DEPTH = DAC_FIFO_DEPTH,
   parameter bit BIPOLAR = 1'b1
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic conversion_start_n,
   input wire logic channel_pair_select,
   input wire logic cs_n,
   input wire logic rd_n,
   output logic busy,
   output logic [DATA_W-1:0] data_out,
   output logic [DATA_W-1:0] data_oe_n,
   input wire logic [DATA_W-1:0] input_a_first,
   input wire logic [DATA_W-1:0] input_a_second,
   input wire logic [DATA_W-1:0] input_b_first,
   input wire logic [DATA_W-1:0] input_b_second,
   output logic sample_valid,
   input wire logic sample_ready,
   output logic [2*DATA_W-1:0] sample_data,
   output logic overrun
);
   initial begin
      if (DATA_W != DAC_DATA_W || CONV_CYC < 2) begin
         $error("dac_ctrl: unsupported width or conversion count");
      end
   end

   // ==========================================================
   // Start edge detection and sampling
   // ==========================================================
   logic start_n_q;
   logic sel_q;
   logic [DATA_W-1:0] hold1_q;
   logic [DATA_W-1:0] hold2_q;
   dac_state_e state_q;
   dac_state_e state_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;

   wire start_fall = start_n_q && !conversion_start_n;
   wire conv_end = (state_q == DAC_CONV) &&
      (cnt_q == 16'(CONV_CYC - 1));
   wire [DATA_W-1:0] pick1 = channel_pair_select ? input_b_first :
      input_a_first;
   wire [DATA_W-1:0] pick2 = channel_pair_select ? input_b_second :
      input_a_second;

   // Start edge tracker; reset high so a start held low through reset gives an edge at release
   always_ff @(posedge sys_clk) begin
      if (sys_rst) start_n_q <= 1'b1;
      else start_n_q <= conversion_start_n;
   end

   // [R1] Both tracks held together
   // Both selected inputs captured in the same edge, keeping phase
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         hold1_q <= '0;
         hold2_q <= '0;
         sel_q <= 1'b0;
      end else if (start_fall && state_q != DAC_CONV) begin
         hold1_q <= pick1;
         hold2_q <= pick2;
         sel_q <= channel_pair_select;
      end
   end

   // ==========================================================
   // Conversion timer, driven by the internal clock only
   // ==========================================================
   // [R16] Internal conversion timing
   // [R2] Fixed conversion span
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         DAC_IDLE, DAC_DONE: begin
            if (start_fall) begin
               state_d = DAC_CONV;
               cnt_d = '0;
            end
         end
         DAC_CONV: begin
            if (conv_end) state_d = DAC_DONE;
            else cnt_d = cnt_q + 16'h0001;
         end
         default: state_d = DAC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q <= DAC_IDLE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // [R15] Busy follows conversion
   // [R3] Busy low means readable
   assign busy = (state_q == DAC_CONV);

   // ==========================================================
   // Output coding
   // ==========================================================
   // Held values are offset binary from the sampler; bipolar parts
   // flip the top bit to give twos complement.
   // [R11] Twos complement coding
   // [R13] Wrap at ground
   // [R14] Bipolar extremes
   // [R12] Straight binary coding
   wire [DATA_W-1:0] code_mask = BIPOLAR ? DAC_SIGN_FLIP : DAC_UNI_MIN;
   wire [DATA_W-1:0] code1 = hold1_q ^ code_mask;
   wire [DATA_W-1:0] code2 = hold2_q ^ code_mask;

   // ==========================================================
   // Output register and read port
   // ==========================================================
   logic [DATA_W-1:0] res1_q;
   logic [DATA_W-1:0] res2_q;
   logic sel_out_q;
   logic ptr_q;
   logic rd_n_q;

   // [R2] Results latched at end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         res1_q <= '0;
         res2_q <= '0;
         sel_out_q <= 1'b0;
      end else if (conv_end) begin
         res1_q <= code1;
         res2_q <= code2;
         sel_out_q <= sel_q;
      end
   end

   wire rd_active = !cs_n && !rd_n;
   wire rd_rise = !rd_n_q && rd_n && !cs_n;

   // [R17] Pointer restart on start
   // [R8] Each read pulse advances
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ptr_q <= 1'b0;
         rd_n_q <= 1'b1;
      end else begin
         rd_n_q <= rd_n;
         if (start_fall) ptr_q <= 1'b0;
         else if (rd_rise) ptr_q <= !ptr_q;
      end
   end

   // [R4] Select low order
   // [R5] Select high order
   // Pair choice is already folded into the held values; the
   // pointer picks first then second of the latched pair.
   wire [DATA_W-1:0] rd_word = ptr_q ? res2_q : res1_q;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) data_out <= '0;
      else data_out <= rd_word;
   end

   // [R18] Drive only during read
   // Enable is combinational so the bus releases as soon as rd rises
   assign data_oe_n = {DATA_W{!rd_active}};

   // ==========================================================
   // Sample stream through the buffer
   // ==========================================================
   logic push_q;
   logic in_ready;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) push_q <= 1'b0;
      else push_q <= conv_end;
   end

   // Full buffer drops the sample and flags it; conversion timing
   // cannot stall because the host owns the start pin.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) overrun <= 1'b0;
      else if (push_q && !in_ready) overrun <= 1'b1;
   end

   dac_fifo #(
      .WIDTH(2*DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(sys_clk),
      .rst(sys_rst),
      .in_valid(push_q),
      .in_ready(in_ready),
      .in_data({res1_q, res2_q}),
      .out_valid(sample_valid),
      .out_ready(sample_ready),
      .out_data(sample_data)
   );

   wire unused_sel = sel_out_q;
endmodule

// [dac_ctrl_asserts.sv]
// Port checks for the dual converter control block
`timescale 1ns/1ps
module dac_ctrl_asserts
   import dac_pkg::*;
#(
   parameter int DATA_W = DAC_DATA_W,
   parameter int CONV_CYC = DAC_CONV_CYC,
   parameter bit BIPOLAR = 1'b1
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic conversion_start_n,
   input wire logic channel_pair_select,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic busy,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic [DATA_W-1:0] data_oe_n,
   input wire logic [DATA_W-1:0] input_a_first,
   input wire logic [DATA_W-1:0] input_a_second,
   input wire logic [DATA_W-1:0] input_b_first,
   input wire logic [DATA_W-1:0] input_b_second,
   input wire logic sample_valid,
   input wire logic sample_ready,
   input wire logic [2*DATA_W-1:0] sample_data
);
   // ====
   // Helper state
   logic st_q, rd_q, rp_q, take;
   logic [DATA_W-1:0] e1_q, e2_q, flip;
   int bcnt_q;
   assign take = st_q & ~conversion_start_n & ~busy;
   assign flip = {BIPOLAR, {(DATA_W-1){1'b0}}};
   // Track start edges, read order and the expected coded pair
   always_ff @(posedge sys_clk) begin
      st_q <= sys_rst | conversion_start_n;
      rd_q <= rd_n;
      bcnt_q <= busy ? bcnt_q + 1 : 0;
      if (sys_rst || take) begin
         rp_q <= 1'b0;
      end else if (!cs_n && !rd_q && rd_n) begin
         rp_q <= ~rp_q;
      end
      if (take) begin
         e1_q <= (channel_pair_select ? input_b_first : input_a_first)
            ^ flip;
         e2_q <= (channel_pair_select ? input_b_second : input_a_second)
            ^ flip;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Read strobe held low long enough for settled data
   sequence s_held_read;
      !busy && !$past(busy, 2) && !cs_n && !rd_n && !rd_q;
   endsequence
   a_busy_rise: assert property (take |=> busy)
      else $error("busy did not rise after start");
   a_busy_len: assert property ($fell(busy) |-> bcnt_q == CONV_CYC)
      else $error("conversion length wrong");
   a_busy_max: assert property (busy |-> bcnt_q < CONV_CYC)
      else $error("busy too long");
   a_oe_drive: assert property (
      data_oe_n == {DATA_W{cs_n | rd_n}})
      else $error("bus enable wrong");
   a_first_word: assert property (
      s_held_read ##0 !rp_q |-> data_out == e1_q)
      else $error("first read word wrong");
   a_second_word: assert property (
      s_held_read ##0 rp_q |-> data_out == e2_q)
      else $error("second read word wrong");
   a_sample_out: assert property (
      $fell(busy) |-> ##[1:3] sample_valid)
      else $error("no sample after conversion");
   a_valid_hold: assert property (sample_valid && !sample_ready |=>
      sample_valid && $stable(sample_data)) else $error("stalled sample lost");
endmodule
bind dac_ctrl dac_ctrl_asserts #(.DATA_W(DATA_W), .CONV_CYC(CONV_CYC),
   .BIPOLAR(BIPOLAR)) u_chk (.sys_clk, .sys_rst, .conversion_start_n,
   .channel_pair_select, .cs_n, .rd_n, .busy, .data_out, .data_oe_n,
   .input_a_first, .input_a_second, .input_b_first, .input_b_second,
   .sample_valid, .sample_ready, .sample_data);

// [dac_fifo.sv]
// Small synchronous FIFO holding converted samples
`timescale 1ns/1ps
module dac_fifo
   import dac_pkg::*;
#(
   parameter int WIDTH = 28,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("dac_fifo depth must be a power of two");
      end
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire empty = (wr_q == rd_q);
   wire push = in_valid && !full;
   wire pop = out_ready && !empty;
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_q[AW-1:0]];
   // Pointers carry one extra wrap bit to tell full from empty
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
      end
   end
   // Storage has no reset; contents are only read when valid
   always_ff @(posedge clk) begin
      if (push) mem[wr_q[AW-1:0]] <= in_data;
   end
endmodule

// [dac_host.sv]
// Host model performing the two-word parallel read
`timescale 1ns/1ps
module dac_host (
   input wire logic sys_clk,
   input wire logic go,
   input wire logic [13:0] data_out,
   input wire logic [13:0] data_oe_n,
   output logic cs_n,
   output logic rd_n,
   output logic [13:0] word,
   output logic word_v,
   output logic done
);
   // ====
   // Released bits read back inverted, never a stale value
   logic [13:0] bus;
   logic [13:0] last_q = '0;
   assign bus = (data_out & ~data_oe_n) | (~last_q & data_oe_n);
   // two strobes inside one chip select
   // Read kept short; two cycles low lets the lagged data settle
   initial begin
      {cs_n, rd_n, word_v, done, word} = {4'b1100, 14'h0000};
      forever begin
         @(posedge sys_clk);
         word_v <= 1'b0;
         done <= 1'b0;
         if (go) begin
            cs_n <= 1'b0;
            repeat (2) begin
               rd_n <= 1'b0;
               repeat (2) @(posedge sys_clk);
               word <= bus;
               last_q <= bus;
               word_v <= 1'b1;
               rd_n <= 1'b1;
               @(posedge sys_clk);
               word_v <= 1'b0;
            end
            cs_n <= 1'b1;
            done <= 1'b1;
         end
      end
   end
endmodule

// [dac_pkg.sv]
// Constants and types shared by the dual converter control block
package dac_pkg;
   localparam int DAC_DATA_W = 14;
   // Conversion time in nanoseconds and the system clock period
   localparam int DAC_CONV_NS = 5200;
   localparam int DAC_CLK_NS = 25;
   // Longest time rounds down to whole cycles
   localparam int DAC_CONV_CYC = DAC_CONV_NS / DAC_CLK_NS;
   localparam int DAC_FIFO_DEPTH = 16;
   // Code limits of the bipolar and unipolar codings
   localparam logic [13:0] DAC_BIP_MAX = 14'h1fff;
   localparam logic [13:0] DAC_BIP_MIN = 14'h2000;
   localparam logic [13:0] DAC_UNI_MAX = 14'h3fff;
   localparam logic [13:0] DAC_UNI_MIN = 14'h0000;
   localparam logic [13:0] DAC_SIGN_FLIP = 14'h2000;
   typedef enum logic [2:0] {
      DAC_IDLE = 3'b001,
      DAC_CONV = 3'b010,
      DAC_DONE = 3'b100
   } dac_state_e;
endpackage

// [tb_top.sv]
// Self-checking bench for the dual converter control block
`timescale 1ns/1ps
module tb_top
   import dac_pkg::*;
;
   // ====
   logic sys_clk = 0, sys_rst, conv_n, sel, go, sample_ready, cs_n, rd_n;
   logic busy, sample_valid, overrun, word_v, done;
   logic [13:0] a1, a2, b1, b2, data_out, data_oe_n, word;
   logic [27:0] sample_data;
   logic [13:0] exp_q[$];
   logic [27:0] smp_q[$];
   int fail_count = 0, n_checks = 0, cycles = 0, pops;
   dac_ctrl #(.CONV_CYC(8)) u_dut (.sys_clk, .sys_rst,
      .conversion_start_n(conv_n), .channel_pair_select(sel), .cs_n, .rd_n,
      .busy, .data_out, .data_oe_n, .input_a_first(a1), .input_a_second(a2),
      .input_b_first(b1), .input_b_second(b2), .sample_valid, .sample_ready,
      .sample_data, .overrun);
   dac_host u_host (.sys_clk, .go, .data_out, .data_oe_n, .cs_n, .rd_n,
      .word, .word_v, .done);
   // 25 ns clock and a cycle ceiling against hangs
   initial forever #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         results();
      end
   end
   task automatic check(logic [27:0] exp, logic [27:0] got, string what);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // One conversion, with a refused second start when i[1] is set, then a host read
   task automatic convert(int i);
      logic [13:0] v[4];
      int n;
      logic [13:0] e1, e2;
      for (n = 0; n < 4; n++) v[n] = 14'($urandom);
      if (i < 2) v = '{14'h3fff, 14'h0000, 14'h2000, 14'h1fff};
      // Select only changes while no conversion runs
      sel <= i[0];
      {a1, a2, b1, b2} <= {v[0], v[1], v[2], v[3]};
      // select settled and quiet gap kept
      repeat (20) @(posedge sys_clk);
      conv_n <= 1'b0;
      e1 = (i[0] ? v[2] : v[0]) ^ DAC_SIGN_FLIP;
      e2 = (i[0] ? v[3] : v[1]) ^ DAC_SIGN_FLIP;
      exp_q.push_back(e1);
      exp_q.push_back(e2);
      // Samples beyond the buffer depth are lost to the overrun
      if (i < DAC_FIFO_DEPTH) smp_q.push_back({e1, e2});
      @(posedge sys_clk) conv_n <= 1'b1;
      @(posedge sys_clk) conv_n <= ~i[1];
      @(posedge sys_clk) conv_n <= 1'b1;
      // Busy tells when reading may begin
      for (n = 0; n < 100 && busy !== 1'b0; n++) @(posedge sys_clk);
      repeat (3) @(posedge sys_clk);
      go <= 1'b1;
      @(posedge sys_clk) go <= 1'b0;
      while (done !== 1'b1) @(posedge sys_clk);
   endtask
   // Each read word is matched against the oldest noted value
   always @(posedge sys_clk) begin
      if (word_v === 1'b1)
         check(exp_q.pop_front(), word, "read word");
   end
   initial begin
      {sys_rst, conv_n, sel, go, sample_ready} = 5'b11000;
      {a1, a2, b1, b2} = '0;
      void'($urandom(92));
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 18; i++) convert(i);
      // Nothing drained yet, so the stream buffer overflowed
      check(14'h0001, 14'(overrun), "overrun");
      sample_ready <= 1'b1;
      pops = 0;
      repeat (40) begin
         @(posedge sys_clk);
         if (sample_valid === 1'b1) begin
            pops++;
            if (smp_q.size() > 0)
               check(smp_q.pop_front(), sample_data, "sample pair");
         end
      end
      check(14'(pops), 14'(DAC_FIFO_DEPTH), "drained samples");
      results();
   end
endmodule
